/* xam_pkg.sv */
// Package for the data-space RAM mapper: map, field layout and carriers.
`default_nettype none
package xam_pkg;
    localparam int unsigned RAM_BYTES      = 1024;
    localparam int unsigned RAM_AW         = 10;
    localparam int unsigned PAGE_AW        = 2;
    localparam logic [7:0]  PAGE_SFR_ADDR  = 8'haa;
    localparam logic [7:0]  PAGE_RST_VAL   = 8'h00;
    localparam int unsigned PAGE_LSB       = 0;
    localparam int unsigned PAGE_MSB       = 1;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        short_addr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xam_move_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } xam_sfr_type;

    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } xam_rsp_type;
endpackage
`default_nettype wire

/* xam_ram.sv */
// Single-port byte RAM with registered read data.
`default_nettype none
module xam_ram #(
    parameter int unsigned AW = 10
) (
    input  wire logic          sys_clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output var  logic [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // The array is sized from AW, so absurd widths are refused here.
    if (AW < 1 || AW > 16) begin : g_bad_aw
        $error("AW must lie between one and sixteen");
    end

    always_ff @(posedge sys_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* xam_mapper.sv */
// Data-space RAM mapper: page register, address forming and RAM access.
//
// Summary of operation
// RL1 - Provide 1024 read/write RAM bytes reached by pointer and indirect moves.
// RL2 - Eight-bit moves take the high address byte from the page register.
// RL3 - Sixteen-bit pointer moves ignore the top six bits; low ten decode.
// RL4 - RAM repeats every 1024 bytes across the whole 64 k space.
// RL5 - Moves go to the RAM unless flash writing has been selected.
// RL6 - Page-select field in bits 1 to 0 picks the 256-byte page.
// RL7 - Unused page register bits always read zero whatever is written.
// RL8 - Page register clears to zero on system reset.
`default_nettype none
module xam_mapper #(
    parameter int unsigned RAM_AW = xam_pkg::RAM_AW
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 flash_write_sel,
    input  wire xam_pkg::xam_move_type move_req,
    input  wire xam_pkg::xam_sfr_type  sfr_req,
    output var  xam_pkg::xam_rsp_type  move_rsp,
    output var  xam_pkg::xam_rsp_type  sfr_rsp,
    output var  logic [7:0]            page_reg_out
);
    import xam_pkg::*;

    // The page field, the byte operand and the RAM must tile the address
    // exactly, otherwise paging and mirroring would disagree.
    if (RAM_AW != PAGE_AW + 8) begin : g_bad_ram_aw
        $error("RAM_AW must equal page bits plus eight");
    end

    if ((1 << RAM_AW) != RAM_BYTES) begin : g_bad_ram_bytes
        $error("RAM_BYTES must equal two to the power RAM_AW");
    end

    if (RAM_AW > 16) begin : g_bad_ram_space
        $error("RAM_AW must fit inside the sixteen-bit data space");
    end

    if (PAGE_MSB - PAGE_LSB + 1 != PAGE_AW) begin : g_bad_page_field
        $error("Page field position must span the page bits");
    end

    if (PAGE_MSB > 7) begin : g_bad_page_msb
        $error("Page field must sit inside the page register byte");
    end

    if ((PAGE_RST_VAL >> (PAGE_MSB + 1)) != 8'h00) begin : g_bad_page_rst
        $error("Page reset value must keep the unused bits at zero");
    end

    // Page register group.
    logic [PAGE_AW-1:0] page_select_field_ff;
    logic [PAGE_AW-1:0] nxt_page_select_field;
    logic [7:0]         page_reg_ff;
    logic [7:0]         nxt_page_reg;

    // Register access answer group.
    xam_rsp_type        sfr_rsp_ff;
    xam_rsp_type        nxt_sfr_rsp;

    // Move answer group.
    logic               move_pend_ff;
    logic               nxt_move_pend;

    // Request decode.
    logic               page_hit;
    logic               page_wr;
    logic               page_rd;
    logic               move_take;
    logic               move_rd;
    logic               move_wr;

    // RAM side.
    logic [15:0]        full_addr;
    logic [RAM_AW-1:0]  ram_addr;
    logic               ram_en;
    logic               ram_we;
    logic [7:0]         ram_wdata;
    logic [7:0]         ram_rdata;

    // A flash write claims the move, so the RAM never sees it.
    always_comb begin
        move_take = move_req.valid && !flash_write_sel; // [RL5]
        move_rd   = move_take && !move_req.write;
        move_wr   = move_take && move_req.write;
    end

    // Only the one page register address answers; all others are ignored.
    always_comb begin
        page_hit = sfr_req.valid && (sfr_req.addr == PAGE_SFR_ADDR);
        page_wr  = page_hit && sfr_req.write;
        page_rd  = page_hit && !sfr_req.write;
    end

    // A short move uses the page value held before the edge that takes it,
    // so a page write and a move in one cycle see the old page.
    always_comb begin
        if (move_req.short_addr) begin
            full_addr = {page_reg_ff, move_req.addr[7:0]}; // [RL2] [RL6]
        end else begin
            full_addr = move_req.addr;
        end
        // Upper bits are dropped so the RAM mirrors through 64 k.
        ram_addr = full_addr[RAM_AW-1:0]; // [RL3] [RL4]
    end

    always_comb begin
        ram_en    = move_take; // [RL5]
        ram_we    = move_wr;
        ram_wdata = move_req.wdata;
    end

    always_comb begin
        nxt_page_select_field = page_select_field_ff;
        if (page_wr) begin
            nxt_page_select_field =
                sfr_req.wdata[PAGE_MSB:PAGE_LSB]; // [RL6]
        end
    end

    // Each byte bit is either a page field bit or a constant zero, so the
    // unused bits can never take a written value.
    for (genvar b = 0; b < 8; b++) begin : g_page_bit
        if (b >= PAGE_LSB && b <= PAGE_MSB) begin : g_field
            assign nxt_page_reg[b] = nxt_page_select_field[b - PAGE_LSB];
        end else begin : g_unused
            assign nxt_page_reg[b] = 1'h0; // [RL7]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_select_field_ff <= PAGE_RST_VAL[PAGE_MSB:PAGE_LSB]; // [RL8]
            page_reg_ff          <= PAGE_RST_VAL; // [RL8]
        end else begin
            page_select_field_ff <= nxt_page_select_field;
            page_reg_ff          <= nxt_page_reg;
        end
    end

    // The read answer carries the whole byte, so the zero upper bits show.
    always_comb begin
        nxt_sfr_rsp.valid = 1'h0;
        nxt_sfr_rsp.data  = sfr_rsp_ff.data;
        if (page_rd) begin
            nxt_sfr_rsp.valid = 1'h1;
            nxt_sfr_rsp.data  = page_reg_ff; // [RL7]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sfr_rsp_ff <= '0;
        end else begin
            sfr_rsp_ff <= nxt_sfr_rsp;
        end
    end

    // Writes give no answer; a read is answered one cycle after it is taken.
    always_comb begin
        nxt_move_pend = move_rd; // [RL1]
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            move_pend_ff <= 1'h0;
        end else begin
            move_pend_ff <= nxt_move_pend;
        end
    end

    // The RAM read register is the output flop for move read data. The RAM
    // is not cleared by reset, so read data is unknown until a first read.
    xam_ram #(
        .AW      (RAM_AW)
    ) u_ram (
        .sys_clk (sys_clk),
        .en      (ram_en),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (ram_wdata),
        .rdata   (ram_rdata)
    ); // [RL1]

    // Outputs are taken straight from their registers.
    always_comb begin
        move_rsp.valid = move_pend_ff;
        move_rsp.data  = ram_rdata;
    end

    always_comb begin
        sfr_rsp = sfr_rsp_ff;
    end

    always_comb begin
        page_reg_out = page_reg_ff;
    end
endmodule
`default_nettype wire

/* xam_checker.sv */
// Port assertions for the data-space RAM mapper.
`default_nettype none
module xam_checker (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  flash_write_sel,
    input wire xam_pkg::xam_move_type move_req,
    input wire xam_pkg::xam_sfr_type  sfr_req,
    input wire xam_pkg::xam_rsp_type  move_rsp,
    input wire xam_pkg::xam_rsp_type  sfr_rsp,
    input wire logic [7:0]            page_reg_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import xam_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rd = move_req.valid & ~move_req.write & ~flash_write_sel;
    wire pg = sfr_req.valid & (sfr_req.addr == PAGE_SFR_ADDR);
    wire pw = pg & sfr_req.write;
    wire pr = pg & ~sfr_req.write;
    wire [7:0] wv = {6'h00, sfr_req.wdata[1:0]};
    move_ans_a: assert property (rd |=> move_rsp.valid)
        else $error("read move not answered");
    flash_quiet_a: assert property (!rd |=> !move_rsp.valid)
        else $error("answer without a RAM read");
    upper_zero_a: assert property (page_reg_out[7:2] == 6'h00)
        else $error("page upper bits set");
    page_wr_a: assert property (pw |=> page_reg_out == $past(wv))
        else $error("page write lost");
    page_keep_a: assert property (!pw |=> $stable(page_reg_out))
        else $error("page changed unasked");
    page_rst_a: assert property ($fell(rst) |-> page_reg_out == 8'h00)
        else $error("page not cleared");
    page_rd_a: assert property (pr |=> sfr_rsp.valid &&
        sfr_rsp.data == $past(page_reg_out)) else $error("page read wrong");
    sfr_skip_a: assert property (!pr |=> !sfr_rsp.valid)
        else $error("stray page answer");
    cover property (pw);
    cover property (rd & move_req.short_addr);
    cover property (flash_write_sel & move_req.valid);
endmodule
`default_nettype wire

/* xam_cpu.sv */
// Core-side model issuing data-space moves and page register accesses.
`default_nettype none
module xam_cpu (
    input  wire logic                  sys_clk,
    input  wire xam_pkg::xam_rsp_type  move_rsp,
    input  wire xam_pkg::xam_rsp_type  sfr_rsp,
    output var  logic                  flash_write_sel,
    output var  xam_pkg::xam_move_type move_req,
    output var  xam_pkg::xam_sfr_type  sfr_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import xam_pkg::*;
    initial {flash_write_sel, move_req, sfr_req} = '0;
    // Control bits are page access, flash select, write and short operand.
    // A request is held across exactly one rising edge, as a core would.
    task automatic go(input logic [3:0] c, input logic [15:0] a,
        input logic [7:0] d, output logic [8:0] r);
        @(negedge sys_clk);
        flash_write_sel = c[2];
        if (c[3])
            sfr_req = '{1'h1, c[1], a[7:0], d};
        else
            move_req = '{1'h1, c[1], c[0], a, d};
        @(negedge sys_clk);
        sfr_req.valid = 1'h0;
        move_req.valid = 1'h0;
        r = c[3] ? sfr_rsp : move_rsp;
        if (!r[8])
            r = 9'h000;
    endtask
endmodule
`default_nettype wire

/* test_onchip_data_ram_address_mapper.sv */
// Self-checking bench for the data-space RAM mapper.
`default_nettype none
module test_onchip_data_ram_address_mapper;
    timeunit 1ns;
    timeprecision 1ps;
    import xam_pkg::*;
    logic         sys_clk = 1'h0;
    logic         rst = 1'h1;
    logic         flash_write_sel;
    xam_move_type move_req;
    xam_sfr_type  sfr_req;
    xam_rsp_type  move_rsp;
    xam_rsp_type  sfr_rsp;
    logic [7:0]   page_reg_out;
    logic [8:0]   r;
    int           miscompares = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    always #2 sys_clk = ~sys_clk;
    xam_mapper xam_mapper_i (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .flash_write_sel (flash_write_sel),
        .move_req        (move_req),
        .sfr_req         (sfr_req),
        .move_rsp        (move_rsp),
        .sfr_rsp         (sfr_rsp),
        .page_reg_out    (page_reg_out)
    );
    xam_cpu xam_cpu_i (
        .sys_clk         (sys_clk),
        .move_rsp        (move_rsp),
        .sfr_rsp         (sfr_rsp),
        .flash_write_sel (flash_write_sel),
        .move_req        (move_req),
        .sfr_req         (sfr_req)
    );
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Writes and refused requests must come back with no answer at all.
    task automatic op(input logic [3:0] c, input logic [15:0] a,
        input logic [7:0] d, input logic [8:0] e);
        xam_cpu_i.go(c, a, d, r);
        chk(r, e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 200) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'h0;
        chk({1'h0, page_reg_out}, 9'h000);
        op(4'ha, 16'h00aa, 8'hff, 9'h000);
        op(4'ha, 16'h00ab, 8'h00, 9'h000);
        op(4'h8, 16'h00aa, 8'h00, 9'h103);
        $display("page test done");
        op(4'h2, 16'h0310, 8'h5a, 9'h000);
        op(4'h1, 16'h0010, 8'h00, 9'h15a);
        op(4'h3, 16'h00ff, 8'h3c, 9'h000);
        op(4'h0, 16'hffff, 8'h00, 9'h13c);
        op(4'h2, 16'h0401, 8'ha5, 9'h000);
        op(4'h0, 16'hfc01, 8'h00, 9'h1a5);
        $display("address test done");
        op(4'h6, 16'h0001, 8'h77, 9'h000);
        op(4'h4, 16'h0001, 8'h00, 9'h000);
        op(4'h0, 16'h0001, 8'h00, 9'h1a5);
        $display("flash test done");
        rst = 1'h1;
        repeat (2) @(negedge sys_clk);
        rst = 1'h0;
        chk({1'h0, page_reg_out}, 9'h000);
        op(4'h1, 16'h0001, 8'h00, 9'h1a5);
        $display("reset test done");
        end_sim();
    end
endmodule
bind xam_mapper xam_checker xam_checker_i (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .flash_write_sel (flash_write_sel),
    .move_req        (move_req),
    .sfr_req         (sfr_req),
    .move_rsp        (move_rsp),
    .sfr_rsp         (sfr_rsp),
    .page_reg_out    (page_reg_out)
);
`default_nettype wire
